/* File: bench/pdp_local_model.sv */
// Local application model that receives posted writes and may stall them
`timescale 1ns/10ps
`default_nettype none
module pdp_local_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic local_select_n,
  input wire logic local_write_strobe_n,
  input wire logic [31:0] local_write_data,
  input wire logic [7:0] hold,
  output logic local_wait_n,
  output logic [31:0] got_data
);
  logic [7:0] cnt_q; // Stall cycles still to insert
  logic busy_q; // A write cycle is in progress
  // ----------------------------------------------------------
  // Stall control: wait goes low at the same edge as the first strobe cycle starts
  // ----------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      local_wait_n <= 1'b1;
      cnt_q <= 8'h00;
      busy_q <= 1'b0;
    end else if (local_select_n) begin
      busy_q <= 1'b0;
    end else if (!busy_q) begin
      // Stall decided on first select cycle, long stalls allowed
      busy_q <= 1'b1;
      cnt_q <= hold;
      local_wait_n <= (hold == 8'h00);
    end else if (cnt_q > 8'h01) begin
      cnt_q <= cnt_q - 8'h01;
    end else begin
      local_wait_n <= 1'b1;
    end
  end
  // Data is taken only in a strobe cycle without stall
  always_ff @(posedge sys_clk) begin
    if (!local_write_strobe_n && local_wait_n) begin
      got_data <= local_write_data;
    end
  end
endmodule : pdp_local_model
`default_nettype wire

/* File: bench/pdp_top_tb.sv */
// Self-checking bench of the PCI port: posting, claims and DMA reads and writes
`timescale 1ns/10ps
`default_nettype none
module pdp_top_tb;
  import pdp_pkg::*;
  logic sys_clk = 0, rst = 1, idsel = 0, gnt_n = 1, m_frame = 1, m_irdy = 1, m_trdy = 1;
  logic m_devsel = 1, dma_armed = 0, dma_write = 0, local_dma_request = 0;
  logic local_dma_wr_valid = 0, cl, rt;
  logic [31:0] dma_address = '0, local_dma_wr_data = '0, m_ad = '0, got;
  logic [31:0] ad_in, ad_out, local_write_data, local_dma_rd_data;
  logic [4:0] dma_words = 5'h01;
  logic [3:0] m_cbe = 4'hf, cbe_n_in, cbe_n_out, local_byte_enables;
  logic [7:0] hold = 8'h00;
  logic ad_oe, cbe_oe, par_in, par_out, par_oe, frame_n_in, frame_n_out, frame_oe;
  logic irdy_n_in, irdy_n_out, irdy_oe, trdy_n_in, trdy_n_out, trdy_oe, stop_n_in;
  logic stop_n_out, stop_oe, devsel_n_in, devsel_n_out, devsel_oe, req_n, local_select_n;
  logic local_write_strobe_n, local_read_strobe_n, local_wait_n, local_dma_wr_ready;
  logic local_dma_rd_valid, dma_done, dma_abort;
  int n_mismatch = 0, samples_checked = 0;
  // Bus wires: the design wins while it drives, else the bench value is seen; only PAR and STOP# float high
  assign ad_in = ad_oe ? ad_out : m_ad;
  assign cbe_n_in = cbe_oe ? cbe_n_out : m_cbe;
  assign par_in = par_oe ? par_out : 1'b1;
  assign frame_n_in = frame_oe ? frame_n_out : m_frame;
  assign irdy_n_in = irdy_oe ? irdy_n_out : m_irdy;
  assign trdy_n_in = trdy_oe ? trdy_n_out : m_trdy;
  assign stop_n_in = stop_oe ? stop_n_out : 1'b1;
  assign devsel_n_in = devsel_oe ? devsel_n_out : m_devsel;
  pdp_top uut (.*);
  pdp_local_model lm (.sys_clk(sys_clk), .rst(rst), .local_select_n(local_select_n),
    .local_write_strobe_n(local_write_strobe_n), .local_write_data(local_write_data),
    .hold(hold), .local_wait_n(local_wait_n), .got_data(got));
  always #5 sys_clk = ~sys_clk;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic summarize;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  // One single-phase access as bus master; reports claim and retry
  task automatic pci_cyc(input logic [3:0] c, input logic [31:0] a, d, input logic [3:0] b,
    input logic s);
    int i;
    @(posedge sys_clk); m_frame <= 0; m_ad <= a; m_cbe <= c; idsel <= s;
    @(posedge sys_clk); m_frame <= 1; m_irdy <= 0; m_ad <= d; m_cbe <= b; idsel <= 0;
    for (i = 0; i < 12; i++) begin
      @(negedge sys_clk);
      if (trdy_oe && !(trdy_n_out && stop_n_out)) break;
    end
    cl = (i < 12) && devsel_n_out === 1'b0;
    rt = stop_n_out === 1'b0 && trdy_n_out === 1'b1;
    @(posedge sys_clk); m_irdy <= 1; m_ad <= ~d; m_cbe <= 4'hf;
    repeat (3) @(posedge sys_clk);
  endtask : pci_cyc
  // Follows one local write cycle and judges its shape
  task automatic local_check(input logic [31:0] d, input logic [3:0] b);
    int i, ns, nw;
    for (i = 0; i < 100 && local_select_n !== 1'b0; i++) @(negedge sys_clk);
    chk("strobe_first", local_write_strobe_n, 1);
    chk("read_strobe", local_read_strobe_n, 1);
    @(negedge sys_clk);
    chk("ben", local_byte_enables, b);
    ns = 0; nw = 0;
    while (local_write_strobe_n === 1'b0 && ns < 300) begin
      chk("wdata", local_write_data, d);
      chk("sel_held", local_select_n, 0);
      ns++; nw += !local_wait_n;
      @(negedge sys_clk);
    end
    chk("strobe_len", ns, nw + 1);
    chk("sel_tail", local_select_n, 0);
    @(negedge sys_clk); chk("sel_end", local_select_n, 1);
    chk("delivered", got, d);
  endtask : local_check
  task automatic post_write;
    fork
      local_check(32'h1234_5678, 4'h5);
      begin pci_cyc(CMD_MEM_WR, 32'h0008_0010, 32'h1234_5678, 4'h5, 0);
        chk("claim", cl, 1); chk("no_retry", rt, 0); end
    join
  endtask : post_write
  task automatic stall_retry;
    @(posedge sys_clk); hold <= 8'h28;
    fork
      local_check(32'ha5a5_0f0f, 4'ha);
      begin pci_cyc(CMD_MEM_WR, 32'h0008_0020, 32'ha5a5_0f0f, 4'ha, 0);
        pci_cyc(CMD_MEM_WR, 32'h0008_0024, 32'h0, 4'h0, 0);
        chk("retry", rt, 1); chk("still_held", local_select_n, 0); end
    join
  endtask : stall_retry
  task automatic cfg_claim;
    pci_cyc(CMD_CFG_RD, 32'h0, 32'h0, 4'h0, 1); chk("cfg_idsel", cl, 1);
    pci_cyc(CMD_CFG_WR, 32'h0, 32'h0, 4'h0, 0); chk("cfg_noid", cl, 0);
  endtask : cfg_claim
  task automatic dma_rd;
    int i;
    @(posedge sys_clk); dma_armed <= 1; dma_address <= 32'h4000_0104;
    repeat (4) @(negedge sys_clk); chk("req_idle", req_n, 1);
    @(posedge sys_clk); local_dma_request <= 1;
    repeat (2) @(negedge sys_clk); chk("req_now", req_n, 0);
    @(posedge sys_clk); gnt_n <= 0;
    for (i = 0; i < 8 && frame_n_out !== 1'b0; i++) @(negedge sys_clk);
    chk("addr", ad_out, 32'h4000_0104); chk("cmd", cbe_n_out, CMD_MEM_RD);
    @(posedge sys_clk); m_devsel <= 0;
    @(negedge sys_clk); chk("ad_rel", ad_oe, 0);
    chk("apar", {par_oe, par_out}, {1'b1, ^{32'h4000_0104, CMD_MEM_RD}});
    @(posedge sys_clk); m_trdy <= 0; m_ad <= 32'hc0ff_ee01;
    @(negedge sys_clk); chk("par_rel", par_oe, 0); chk("irdy_c4", irdy_n_out, 1);
    @(negedge sys_clk); chk("irdy_c5", {irdy_n_out, frame_n_out}, 2'b01);
    chk("cbe_c5", cbe_oe, 1);
    @(posedge sys_clk); m_trdy <= 1; m_devsel <= 1; m_ad <= 32'h3f00_11fe; gnt_n <= 1;
    local_dma_request <= 0;
    @(negedge sys_clk); chk("cbe_rel", cbe_oe, 0);
    chk("rd_valid", local_dma_rd_valid, 1);
    chk("rdata", local_dma_rd_data, 32'hc0ff_ee01);
    for (i = 0; i < 4 && dma_done !== 1'b1; i++) @(negedge sys_clk);
    chk("done", dma_done, 1);
  endtask : dma_rd
  task automatic dma_wr;
    int i;
    @(posedge sys_clk); dma_write <= 1; dma_words <= 5'h02; local_dma_request <= 1;
    repeat (6) @(negedge sys_clk); chk("wr_noreq", {req_n, local_dma_wr_ready}, 2'b11);
    @(posedge sys_clk); local_dma_wr_valid <= 1; local_dma_wr_data <= 32'h0000_0011;
    @(posedge sys_clk); local_dma_wr_data <= 32'h0000_0022;
    @(posedge sys_clk); local_dma_wr_valid <= 0;
    for (i = 0; i < 8 && req_n !== 1'b0; i++) @(negedge sys_clk);
    chk("wr_req", req_n, 0);
    @(posedge sys_clk); gnt_n <= 0; m_devsel <= 0; m_trdy <= 0;
    for (i = 0; i < 8 && frame_n_out !== 1'b0; i++) @(negedge sys_clk);
    repeat (2) @(negedge sys_clk); chk("wr_c4", {irdy_n_out, ad_oe}, 2'b10);
    @(negedge sys_clk); chk("wr_c5", {irdy_n_out, ad_oe}, 2'b01);
    chk("wd0", ad_out, 32'h0000_0011);
    @(negedge sys_clk); chk("wd1", ad_out, 32'h0000_0022);
    @(posedge sys_clk); gnt_n <= 1; m_devsel <= 1; m_trdy <= 1; local_dma_request <= 0;
    dma_write <= 0;
    for (i = 0; i < 4 && dma_done !== 1'b1; i++) @(negedge sys_clk);
    chk("wr_done", {dma_done, dma_abort}, 2'b10);
  endtask : dma_wr
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 0;
    post_write();
    stall_retry();
    cfg_claim();
    dma_rd();
    dma_wr();
    summarize();
  end
  // Watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    summarize();
  end
endmodule : pdp_top_tb
`default_nettype wire

/* File: design/pdp_dma_buf.sv */
// DMA write buffer filled from the local side before a master write
`timescale 1ns/10ps
`default_nettype none
module pdp_dma_buf #(
  parameter int DEPTH = pdp_pkg::BUF_WORDS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic fill_start,
  input wire logic [4:0] fill_words,
  input wire logic [31:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  output logic full,
  input wire logic [3:0] rd_idx,
  output logic [31:0] rd_data
);
  import pdp_pkg::*;

  if (DEPTH < 2 || DEPTH > 16) begin : g_depth_chk
    $error("DEPTH must be 2 to 16");
  end

  logic [31:0] mem_q [DEPTH]; // Buffer words
  logic [4:0] cnt_q; // Words stored so far
  logic [4:0] goal_q; // Words wanted for this transfer
  logic filling_q; // Set by fill start, held until reset

  // ---------------------------------------------------------------
  // Fill control
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= 5'h0;
      goal_q <= 5'h0;
      filling_q <= 1'b0;
    end else if (fill_start) begin
      cnt_q <= 5'h0;
      goal_q <= fill_words;
      filling_q <= 1'b1;
    end else if (wr_valid && wr_ready) begin
      cnt_q <= cnt_q + 5'h1;
    end
  end

  // Storage, written in arrival order
  always_ff @(posedge sys_clk) begin
    if (wr_valid && wr_ready) begin
      mem_q[cnt_q[3:0]] <= wr_data;
    end
  end

  assign wr_ready = filling_q && (cnt_q < goal_q);
  assign full = filling_q && (cnt_q == goal_q);
  assign rd_data = mem_q[rd_idx];
endmodule : pdp_dma_buf
`default_nettype wire

/* File: design/pdp_local_wr.sv */
// Local-side write cycle sequencer for posted target writes
`timescale 1ns/10ps
`default_nettype none
module pdp_local_wr (
  input wire logic sys_clk,
  input wire logic rst,
  pdp_post_if.snk post,
  input wire logic local_wait_n,
  output logic local_select_n,
  output logic local_write_strobe_n,
  output logic local_read_strobe_n,
  output logic [31:0] local_write_data,
  output logic [3:0] local_byte_enables
);
  import pdp_pkg::*;

  pdp_loc_state_type state_q; // Sequencer state

  // ---------------------------------------------------------------
  // Select, strobe and wait sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= L_IDLE;
    end else begin
      case (state_q)
        L_IDLE: if (post.valid) state_q <= L_SEL;
        L_SEL: state_q <= L_STROBE;
        L_STROBE: if (local_wait_n) state_q <= L_REL;
        default: state_q <= L_IDLE;
      endcase
    end
  end

  // Data and byte enables latched when the strobe goes out
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      local_write_data <= 32'h0;
      local_byte_enables <= 4'hf;
    end else if (state_q == L_SEL) begin
      local_write_data <= post.data;
      local_byte_enables <= post.ben;
    end
  end

  // Select and write strobe decoded from state flops; read strobe tied high
  assign local_select_n = (state_q == L_IDLE);
  assign local_write_strobe_n = (state_q != L_STROBE);
  assign local_read_strobe_n = 1'b1;
  assign post.done = (state_q == L_REL);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  strobe_after_select_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(local_select_n) |-> local_write_strobe_n ##1 !local_write_strobe_n)
    else $error("write strobe not one clock after select");
  wait_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !local_write_strobe_n && !local_wait_n |=> !local_write_strobe_n && !local_select_n
      && $stable(local_write_data))
    else $error("write cycle not held during wait");
  deselect_after_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(local_write_strobe_n) |-> !local_select_n ##1 local_select_n)
    else $error("select not released one clock after strobe");
  no_read_strobe_a: assert property (@(posedge sys_clk) disable iff (rst)
    !local_select_n |-> local_read_strobe_n)
    else $error("read strobe active in write cycle");
  ben_copy_a: assert property (@(posedge sys_clk) disable iff (rst)
    !local_write_strobe_n |-> local_byte_enables == post.ben)
    else $error("byte enables differ from captured ones");
  wait_stretch_c: cover property (@(posedge sys_clk) disable iff (rst)
    !local_write_strobe_n && !local_wait_n ##1 !local_wait_n ##1 local_wait_n);
endmodule : pdp_local_wr
`default_nettype wire

/* File: design/pdp_top.sv */
// PCI target posting, configuration claim and DMA bus-master port
`timescale 1ns/10ps
`default_nettype none
module pdp_top #(
  parameter logic [31:pdp_pkg::REGION_BITS] BASE_ADDR = '0,
  parameter int BUF_DEPTH = pdp_pkg::BUF_WORDS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [31:0] ad_in,
  output logic [31:0] ad_out,
  output logic ad_oe,
  input wire logic [3:0] cbe_n_in,
  output logic [3:0] cbe_n_out,
  output logic cbe_oe,
  input wire logic par_in,
  output logic par_out,
  output logic par_oe,
  input wire logic frame_n_in,
  output logic frame_n_out,
  output logic frame_oe,
  input wire logic irdy_n_in,
  output logic irdy_n_out,
  output logic irdy_oe,
  input wire logic trdy_n_in,
  output logic trdy_n_out,
  output logic trdy_oe,
  input wire logic stop_n_in,
  output logic stop_n_out,
  output logic stop_oe,
  input wire logic devsel_n_in,
  output logic devsel_n_out,
  output logic devsel_oe,
  input wire logic idsel,
  output logic req_n,
  input wire logic gnt_n,
  output logic local_select_n,
  output logic local_write_strobe_n,
  output logic local_read_strobe_n,
  output logic [31:0] local_write_data,
  output logic [3:0] local_byte_enables,
  input wire logic local_wait_n,
  input wire logic dma_armed,
  input wire logic dma_write,
  input wire logic [31:0] dma_address,
  input wire logic [4:0] dma_words,
  input wire logic local_dma_request,
  input wire logic [31:0] local_dma_wr_data,
  input wire logic local_dma_wr_valid,
  output logic local_dma_wr_ready,
  output logic [31:0] local_dma_rd_data,
  output logic local_dma_rd_valid,
  output logic dma_done,
  output logic dma_abort
);
  import pdp_pkg::*;

  if (BUF_DEPTH < 2 || BUF_DEPTH > BUF_WORDS) begin : g_cfg_chk
    $error("BUF_DEPTH out of range");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  pdp_post_if post (); // Holding register link to local sequencer
  pdp_tgt_state_type t_q; // Target state
  pdp_mst_state_type m_q; // Master state
  logic frame_prev_q; // FRAME# one clock ago, for address phase edge
  logic retry_q; // Claimed access is being retried
  logic post_hit_q; // Claimed access is a posted external write
  logic cfg_rd_q; // Claimed access is a configuration read
  logic addr_phase; // Address phase of another master
  logic ext_hit; // Memory write into the external region
  logic cfg_hit; // Configuration access to this device
  logic [31:0] m_ad_q; // Master AD drive value
  logic m_ad_oe_q; // Master drives AD
  logic [2:0] ph_q; // Clocks since the master address phase
  logic [4:0] left_q; // Data phases still to run
  logic [3:0] idx_q; // Buffer word on AD
  logic [3:0] idx_nxt; // Buffer word to load next
  logic dir_wr_q; // Current DMA is a PCI write
  logic xfer; // Master data phase completes
  logic buf_full; // Write buffer holds the wanted words
  logic [31:0] buf_word; // Buffer word at idx_nxt

  // ---------------------------------------------------------------
  // Target decode
  // ---------------------------------------------------------------
  assign addr_phase = (t_q == T_IDLE) && frame_prev_q && !frame_n_in && !frame_oe;
  assign ext_hit = (cbe_n_in == CMD_MEM_WR) && ad_in[REGION_BITS-1]
                   && (ad_in[31:REGION_BITS] == BASE_ADDR);
  assign cfg_hit = idsel && ((cbe_n_in == CMD_CFG_RD) || (cbe_n_in == CMD_CFG_WR));

  // Edge history of FRAME#
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      frame_prev_q <= 1'b1;
    end else begin
      frame_prev_q <= frame_n_in;
    end
  end

  // Target state: claim, single data phase with disconnect, turnaround
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      t_q <= T_IDLE;
      retry_q <= 1'b0;
      post_hit_q <= 1'b0;
      cfg_rd_q <= 1'b0;
    end else begin
      case (t_q)
        T_IDLE: begin
          if (addr_phase && (ext_hit || cfg_hit)) begin
            t_q <= T_CLAIM;
            retry_q <= post.valid;
            post_hit_q <= ext_hit;
            cfg_rd_q <= cfg_hit && (cbe_n_in == CMD_CFG_RD);
          end
        end
        T_CLAIM: t_q <= T_DATA;
        T_DATA: if (!irdy_n_in) t_q <= T_TURN;
        default: t_q <= T_IDLE;
      endcase
    end
  end

  // Target control pins, driven high one clock before release
  assign devsel_oe = (t_q != T_IDLE);
  assign trdy_oe = devsel_oe;
  assign stop_oe = devsel_oe;
  assign devsel_n_out = !((t_q == T_CLAIM) || (t_q == T_DATA));
  assign trdy_n_out = !((t_q == T_DATA) && !retry_q);
  assign stop_n_out = (t_q != T_DATA);

  // ---------------------------------------------------------------
  // Holding registers for posted writes
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      post.valid <= 1'b0;
      post.addr <= 32'h0;
      post.data <= 32'h0;
      post.ben <= 4'hf;
    end else if (addr_phase && ext_hit && !post.valid) begin
      post.addr <= ad_in;
    end else if ((t_q == T_DATA) && !irdy_n_in && post_hit_q && !retry_q) begin
      post.valid <= 1'b1;
      post.data <= ad_in;
      post.ben <= cbe_n_in;
    end else if (post.done) begin
      post.valid <= 1'b0;
    end
  end

  pdp_local_wr u_local_wr (
    .sys_clk(sys_clk),
    .rst(rst),
    .post(post),
    .local_wait_n(local_wait_n),
    .local_select_n(local_select_n),
    .local_write_strobe_n(local_write_strobe_n),
    .local_read_strobe_n(local_read_strobe_n),
    .local_write_data(local_write_data),
    .local_byte_enables(local_byte_enables)
  );

  // ---------------------------------------------------------------
  // DMA write buffer
  // ---------------------------------------------------------------
  assign idx_nxt = (m_q == M_DATA) ? idx_q + 4'h1 : 4'h0;

  pdp_dma_buf #(.DEPTH(BUF_DEPTH)) u_buf (
    .sys_clk(sys_clk),
    .rst(rst),
    .fill_start((m_q == M_IDLE) && dma_armed && local_dma_request && dma_write),
    .fill_words(dma_words),
    .wr_data(local_dma_wr_data),
    .wr_valid(local_dma_wr_valid),
    .wr_ready(local_dma_wr_ready),
    .full(buf_full),
    .rd_idx(idx_nxt),
    .rd_data(buf_word)
  );

  // ---------------------------------------------------------------
  // Bus master sequencer
  // ---------------------------------------------------------------
  assign xfer = (m_q == M_DATA) && !trdy_n_in;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      m_q <= M_IDLE;
      req_n <= 1'b1;
      frame_n_out <= 1'b1;
      frame_oe <= 1'b0;
      irdy_n_out <= 1'b1;
      irdy_oe <= 1'b0;
      cbe_n_out <= 4'hf;
      cbe_oe <= 1'b0;
      m_ad_q <= 32'h0;
      m_ad_oe_q <= 1'b0;
      ph_q <= 3'h0;
      left_q <= 5'h0;
      idx_q <= 4'h0;
      dir_wr_q <= 1'b0;
      dma_done <= 1'b0;
      dma_abort <= 1'b0;
    end else begin
      dma_done <= 1'b0;
      dma_abort <= 1'b0;
      ph_q <= (ph_q == PH_MAX) ? ph_q : ph_q + 3'h1;
      case (m_q)
        M_IDLE: begin
          if (dma_armed && local_dma_request && dma_words != 5'h0) begin
            dir_wr_q <= dma_write;
            left_q <= dma_words;
            if (dma_write) begin
              m_q <= M_FILL;
            end else begin
              m_q <= M_REQ;
              req_n <= 1'b0;
            end
          end
        end
        M_FILL: begin
          if (buf_full) begin
            m_q <= M_REQ;
            req_n <= 1'b0;
          end
        end
        M_REQ: begin
          if (!gnt_n && frame_n_in && irdy_n_in && (t_q == T_IDLE)) begin
            m_q <= M_ADDR;
            req_n <= 1'b1;
            frame_n_out <= 1'b0;
            frame_oe <= 1'b1;
            m_ad_q <= dma_address;
            m_ad_oe_q <= 1'b1;
            cbe_n_out <= dir_wr_q ? CMD_MEM_WR : CMD_MEM_RD;
            cbe_oe <= 1'b1;
            ph_q <= 3'h0;
          end
        end
        M_ADDR: begin
          m_q <= M_WAIT;
          m_ad_oe_q <= 1'b0;
          m_ad_q <= 32'h0;
          cbe_n_out <= BEN_ALL;
        end
        M_WAIT: begin
          if (ph_q == PH_LAST_WAIT) begin
            m_q <= M_DATA;
            irdy_n_out <= 1'b0;
            irdy_oe <= 1'b1;
            frame_n_out <= (left_q == 5'h1);
            idx_q <= 4'h0;
            m_ad_q <= dir_wr_q ? buf_word : 32'h0;
            m_ad_oe_q <= dir_wr_q;
          end
        end
        M_DATA: begin
          if (xfer) begin
            left_q <= left_q - 5'h1;
            idx_q <= idx_nxt;
            m_ad_q <= dir_wr_q ? buf_word : 32'h0;
          end
          if ((xfer && left_q == 5'h1) || !stop_n_in
              || (devsel_n_in && ph_q == PH_ABORT)) begin
            m_q <= M_TURN;
            irdy_n_out <= 1'b1;
            frame_n_out <= 1'b1;
            frame_oe <= 1'b0;
            cbe_oe <= 1'b0;
            m_ad_oe_q <= 1'b0;
            dma_abort <= devsel_n_in && ph_q == PH_ABORT;
          end else if (xfer && left_q == 5'h2) begin
            frame_n_out <= 1'b1;
          end
        end
        default: begin
          m_q <= M_IDLE;
          irdy_oe <= 1'b0;
          cbe_n_out <= 4'hf;
          dma_done <= 1'b1;
        end
      endcase
    end
  end

  // Read data handed to the local side per data phase
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      local_dma_rd_data <= 32'h0;
      local_dma_rd_valid <= 1'b0;
    end else begin
      local_dma_rd_valid <= xfer && !dir_wr_q;
      if (xfer && !dir_wr_q) local_dma_rd_data <= ad_in;
    end
  end

  // ---------------------------------------------------------------
  // Shared AD and parity drive
  // ---------------------------------------------------------------
  assign ad_out = m_ad_q;
  assign ad_oe = m_ad_oe_q || ((t_q == T_DATA) && cfg_rd_q && !retry_q);

  // Parity follows the AD and C/BE# values one clock later
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      par_out <= 1'b0;
      par_oe <= 1'b0;
    end else begin
      par_out <= ^{ad_out, cbe_n_out};
      par_oe <= ad_oe;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  post_capture_a: assert property (@(posedge sys_clk) disable iff (rst)
    (t_q == T_DATA) && !irdy_n_in && post_hit_q && !retry_q
      |=> post.valid && post.data == $past(ad_in) && local_select_n)
    else $error("posted write not held before local cycle");
  retry_busy_a: assert property (@(posedge sys_clk) disable iff (rst)
    addr_phase && ext_hit && post.valid |=> ##1 !stop_n_out && trdy_n_out)
    else $error("access not retried while write pending");
  cfg_claim_a: assert property (@(posedge sys_clk) disable iff (rst)
    addr_phase && cfg_hit |=> !devsel_n_out && devsel_oe)
    else $error("configuration access not claimed");
  req_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (m_q == M_IDLE) && dma_armed && local_dma_request && !dma_write && dma_words != 5'h0
      |=> !req_n)
    else $error("DMA read did not request bus");
  req_after_fill_a: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(req_n) && dir_wr_q |-> $past(buf_full))
    else $error("bus requested before buffer filled");
  no_early_irdy_a: assert property (@(posedge sys_clk) disable iff (rst)
    m_q == M_ADDR |=> (irdy_n_out && !frame_n_out && !m_ad_oe_q) [*2] ##1 !irdy_n_out)
    else $error("data phase not at clock five");
  addr_par_a: assert property (@(posedge sys_clk) disable iff (rst)
    m_q == M_ADDR |=> par_oe && par_out == ^{$past(ad_out), $past(cbe_n_out)})
    else $error("address parity wrong in clock three");
  read_release_a: assert property (@(posedge sys_clk) disable iff (rst)
    m_q == M_ADDR && !dir_wr_q |=> !ad_oe ##1 !par_oe)
    else $error("AD or PAR not released in time");
  last_frame_a: assert property (@(posedge sys_clk) disable iff (rst)
    m_q == M_DATA && left_q == 5'h1 |-> frame_n_out && !irdy_n_out)
    else $error("FRAME# asserted in last data phase");
  post_write_c: cover property (@(posedge sys_clk) disable iff (rst)
    post.valid ##[1:20] post.done);
  dma_read_c: cover property (@(posedge sys_clk) disable iff (rst)
    !dir_wr_q && m_q == M_DATA ##1 m_q == M_DATA ##[1:20] dma_done);
  dma_write_c: cover property (@(posedge sys_clk) disable iff (rst)
    m_q == M_FILL ##[1:60] dma_done);
endmodule : pdp_top
`default_nettype wire

/* File: inc/pdp_pkg.sv */
// Shared constants and state types of the PCI port
package pdp_pkg;
  // ---------------------------------------------------------------
  // PCI bus commands
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_MEM_RD = 4'h6; // Memory read
  localparam logic [3:0] CMD_MEM_WR = 4'h7; // Memory write
  localparam logic [3:0] CMD_CFG_RD = 4'ha; // Configuration read
  localparam logic [3:0] CMD_CFG_WR = 4'hb; // Configuration write
  localparam logic [3:0] BEN_ALL = 4'h0; // All byte lanes enabled
  // ---------------------------------------------------------------
  // Sizes and master phase counts (0 = address phase clock)
  // ---------------------------------------------------------------
  localparam int BUF_WORDS = 16; // Write buffer depth in DWORDs
  localparam int REGION_BITS = 20; // Decoded target window size
  localparam logic [2:0] PH_LAST_WAIT = 3'h2; // Clock four
  localparam logic [2:0] PH_ABORT = 3'h7; // No DEVSEL# by then: abort
  localparam logic [2:0] PH_MAX = 3'h7; // Phase counter saturation
  // ---------------------------------------------------------------
  // State types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    T_IDLE = 2'b00, T_CLAIM = 2'b01, T_DATA = 2'b11, T_TURN = 2'b10
  } pdp_tgt_state_type;
  typedef enum logic [2:0] {
    M_IDLE = 3'b000, M_FILL = 3'b001, M_REQ = 3'b011, M_ADDR = 3'b010,
    M_WAIT = 3'b110, M_DATA = 3'b111, M_TURN = 3'b101
  } pdp_mst_state_type;
  typedef enum logic [1:0] {
    L_IDLE = 2'b00, L_SEL = 2'b01, L_STROBE = 2'b11, L_REL = 2'b10
  } pdp_loc_state_type;
endpackage : pdp_pkg

/* File: inc/pdp_post_if.sv */
// Posted write hand-over between PCI target and local write sequencer
`timescale 1ns/10ps
`default_nettype none
interface pdp_post_if;
  logic valid; // Holding registers hold an undelivered write
  logic [31:0] addr; // Held address
  logic [31:0] data; // Held data
  logic [3:0] ben; // Held byte enables, active low
  logic done; // Local side accepted the write
  modport src (output valid, output addr, output data, output ben, input done);
  modport snk (input valid, input addr, input data, input ben, output done);
endinterface : pdp_post_if
`default_nettype wire
